// file: bridge_status_pkg.sv
package bridge_status_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_FAULT       = 8'h52;
   localparam logic [7:0]  IDX_DELAY1      = 8'h53;
   localparam logic [7:0]  IDX_DELAY2      = 8'h54;
   localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h60;
   localparam logic [7:0]  IDX_IRQ_MASK    = 8'h61;

   // Fault status field positions
   localparam int          FLT_HIGH1       = 0;
   localparam int          FLT_LOW1        = 1;
   localparam int          FLT_HIGH2       = 2;
   localparam int          FLT_LOW2        = 3;
   localparam int          FLT_HIGH3       = 4;
   localparam int          FLT_LOW3        = 5;
   localparam int          FLT_LOW1_BRK    = 8;
   localparam int          FLT_LOW2_BRK    = 9;
   localparam int          FLT_LOW3_BRK    = 10;
   localparam int          FLT_MAIN_BRAKE  = 12;
   localparam int          FLT_INT_BRAKE   = 13;
   localparam int          FLT_OVERCURRENT = 14;

   // Implemented flag bits; bits 15, 11, 7 and 6 are reserved
   localparam logic [15:0] FAULT_FLAG_MASK = 16'h773F;
   localparam logic [15:0] FAULT_RESET     = 16'h0000;

   // Delay register layout; bits 15:14 and 7:6 are reserved
   localparam int          DELAY_W         = 6;
   localparam int          DELAY_OFF_LSB   = 8;
   localparam int          DELAY_ON_LSB    = 0;
   localparam logic [15:0] DELAY_RESET     = 16'h0000;

   // Interrupt status and mask layout
   localparam int          IRQ_W           = 2;
   localparam int          IRQ_FAULT       = 0;
   localparam int          IRQ_DELAY       = 1;
   localparam logic [1:0]  IRQ_RESET       = 2'h0;

   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
   localparam logic        HRESP_OKAY      = 1'h0;

   typedef enum logic [1:0] {
      BUS_IDLE  = 2'h1,
      BUS_WRITE = 2'h2
   } bus_state_t;

endpackage

// file: bridge_fault_delay_status_regs.sv
// Contract
// - Reserved bits 15,11,7,6 of faults and 15:14, 7:6 of delays read zero.
// - Bit 14 sets on sense overcurrent and holds until the register is read.
// - Bit 13 latches internal supply overvoltage brake condition; read clears it.
// - Bit 12 latches main supply overvoltage brake condition; read clears it.
// - Bits 8, 9, 10 latch low-side 1, 2, 3 overvoltage while braking; read-clear.
// - Bits 0..5 latch high1, low1, high2, low2, high3, low3 overvoltage; read-clear.
// - Power-on or soft reset zeroes faults; restart keeps latched fault bits.
// - Bridge 1 delay bits 13:8 give measured turn-off delay in 53.3 ns steps.
// - Bridge 1 delay bits 5:0 give measured turn-on delay in 53.3 ns steps.
// - Bridge 2 delay bits 13:8 give turn-off delay as 6-bit 53.3 ns count.
// - Bridge 2 delay bits 5:0 give turn-on delay as 6-bit 53.3 ns count.
// - Power-on or soft reset zeroes delay registers; restart keeps delay fields.
module bridge_fault_delay_status_regs
   import bridge_status_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                ce,
   // AHB-Lite slave
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic [31:0]              hrdata,
   output logic                     hresp,
   // Fault detector levels (asynchronous)
   input  wire logic                high1_overvoltage,
   input  wire logic                low1_overvoltage,
   input  wire logic                high2_overvoltage,
   input  wire logic                low2_overvoltage,
   input  wire logic                high3_overvoltage,
   input  wire logic                low3_overvoltage,
   input  wire logic                low1_brake_overvoltage,
   input  wire logic                low2_brake_overvoltage,
   input  wire logic                low3_brake_overvoltage,
   input  wire logic                main_supply_brake_flag,
   input  wire logic                internal_supply_brake_flag,
   input  wire logic                sense_overcurrent_flag,
   // Delay measurements (same clock)
   input  wire logic                bridge1_meas_valid,
   input  wire logic [DELAY_W-1:0]  bridge1_off_delay,
   input  wire logic [DELAY_W-1:0]  bridge1_on_delay,
   input  wire logic                bridge2_meas_valid,
   input  wire logic [DELAY_W-1:0]  bridge2_off_delay,
   input  wire logic [DELAY_W-1:0]  bridge2_on_delay,
   // Reset classes (same clock pulses)
   input  wire logic                soft_reset,
   input  wire logic                restart,
   // Interrupt
   output logic                     irq
);

   localparam int BRIDGES = 2;

   logic [15:0]         fault_raw;
   logic [15:0]         sync1_q;
   logic [15:0]         sync2_q;
   logic [15:0]         fault_event;
   logic [15:0]         fault_q;
   logic [15:0]         delay_q [BRIDGES];
   logic [BRIDGES-1:0]  meas_valid;
   logic [DELAY_W-1:0]  meas_off [BRIDGES];
   logic [DELAY_W-1:0]  meas_on [BRIDGES];
   logic                addr_phase;
   logic [7:0]          addr_idx;
   logic                rd_fault;
   logic [15:0]         rd_mux;
   bus_state_t          bus_q;
   logic [7:0]          wr_idx_q;
   logic                wr_data_phase;
   logic [IRQ_W-1:0]    irq_event;
   logic [IRQ_W-1:0]    irq_status_q;
   logic [IRQ_W-1:0]    irq_mask_q;
   logic [IRQ_W-1:0]    irq_clear;

   // Gather detector pins into the register layout
   always_comb
   begin
      fault_raw                  = 16'h0000;
      fault_raw[FLT_HIGH1]       = high1_overvoltage;
      fault_raw[FLT_LOW1]        = low1_overvoltage;
      fault_raw[FLT_HIGH2]       = high2_overvoltage;
      fault_raw[FLT_LOW2]        = low2_overvoltage;
      fault_raw[FLT_HIGH3]       = high3_overvoltage;
      fault_raw[FLT_LOW3]        = low3_overvoltage;
      fault_raw[FLT_LOW1_BRK]    = low1_brake_overvoltage;
      fault_raw[FLT_LOW2_BRK]    = low2_brake_overvoltage;
      fault_raw[FLT_LOW3_BRK]    = low3_brake_overvoltage;
      fault_raw[FLT_MAIN_BRAKE]  = main_supply_brake_flag;
      fault_raw[FLT_INT_BRAKE]   = internal_supply_brake_flag;
      fault_raw[FLT_OVERCURRENT] = sense_overcurrent_flag;
   end

   // Two-flop synchroniser per detector bit
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++)
      begin : g_sync
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end
            else if (ce)
            begin
               sync1_q[gi] <= fault_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   assign fault_event = sync2_q & FAULT_FLAG_MASK;

   // Bus address phase decode
   assign addr_phase    = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
   assign addr_idx      = haddr[9:2];
   assign rd_fault      = addr_phase && !hwrite && (addr_idx == IDX_FAULT);
   assign wr_data_phase = (bus_q == BUS_WRITE);

   // Fault flags: detector sets, read clears, set wins over the clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         fault_q <= FAULT_RESET;
      else if (ce)
      begin
         if (soft_reset)
            fault_q <= FAULT_RESET;
         else if (rd_fault)
            fault_q <= fault_event;
         else
            fault_q <= fault_q | fault_event;
      end
   end

   assign meas_valid  = {bridge2_meas_valid, bridge1_meas_valid};
   assign meas_off[0] = bridge1_off_delay;
   assign meas_off[1] = bridge2_off_delay;
   assign meas_on[0]  = bridge1_on_delay;
   assign meas_on[1]  = bridge2_on_delay;

   // Delay registers, updated on each completed measurement
   genvar gb;
   generate
      for (gb = 0; gb < BRIDGES; gb++)
      begin : g_delay
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               delay_q[gb] <= DELAY_RESET;
            else if (ce)
            begin
               if (soft_reset)
                  delay_q[gb] <= DELAY_RESET;
               else if (meas_valid[gb])
               begin
                  delay_q[gb]                                <= DELAY_RESET;
                  delay_q[gb][DELAY_OFF_LSB +: DELAY_W]      <= meas_off[gb];
                  delay_q[gb][DELAY_ON_LSB +: DELAY_W]       <= meas_on[gb];
               end
            end
         end
      end
   endgenerate

   // Read mux
   always_comb
   begin
      rd_mux = 16'h0000;
      case (addr_idx)
         IDX_FAULT:      rd_mux = fault_q & FAULT_FLAG_MASK;
         IDX_DELAY1:     rd_mux = delay_q[0];
         IDX_DELAY2:     rd_mux = delay_q[1];
         IDX_IRQ_STATUS: rd_mux = {14'h0000, irq_status_q};
         IDX_IRQ_MASK:   rd_mux = {14'h0000, irq_mask_q};
         default:        rd_mux = 16'h0000;
      endcase
   end

   // Bus state: zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus_q    <= BUS_IDLE;
         wr_idx_q <= 8'h00;
      end
      else if (ce)
      begin
         case (bus_q)
            BUS_IDLE, BUS_WRITE:
            begin
               if (addr_phase && hwrite)
               begin
                  bus_q    <= BUS_WRITE;
                  wr_idx_q <= addr_idx;
               end
               else
                  bus_q <= BUS_IDLE;
            end
            default:
               bus_q <= BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
         hrdata    <= 32'h0000_0000;
      end
      else if (ce)
      begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
         if (addr_phase && !hwrite)
            hrdata <= {16'h0000, rd_mux};
      end
   end

   // Interrupt events: a newly latched fault or a delay update
   assign irq_event[IRQ_FAULT] = |(fault_event & ~fault_q) || (rd_fault && |fault_event);
   assign irq_event[IRQ_DELAY] = |meas_valid;
   assign irq_clear = (wr_data_phase && wr_idx_q == IDX_IRQ_STATUS) ? hwdata[IRQ_W-1:0] : IRQ_RESET;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_status_q <= IRQ_RESET;
      else if (ce)
      begin
         if (soft_reset || restart)
            irq_status_q <= IRQ_RESET;
         else
            irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_mask_q <= IRQ_RESET;
      else if (ce)
      begin
         if (soft_reset)
            irq_mask_q <= IRQ_RESET;
         else if (wr_data_phase && wr_idx_q == IDX_IRQ_MASK)
            irq_mask_q <= hwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq <= 1'b0;
      else if (ce)
         irq <= |(irq_status_q & irq_mask_q);
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence quiet_s;
      ce && !soft_reset;
   endsequence

   sequence fault_read_s;
      quiet_s ##0 rd_fault && (fault_event == 16'h0000);
   endsequence

   sequence restart_only_s;
      quiet_s ##0 restart && !rd_fault && (fault_event == 16'h0000) && (meas_valid == 2'h0);
   endsequence

   AST_RESERVED_ZERO: assert property (
      ((fault_q & ~FAULT_FLAG_MASK) == 16'h0000) && ((delay_q[0] & 16'hC0C0) == 16'h0000)
      && ((delay_q[1] & 16'hC0C0) == 16'h0000))
      else $error("reserved bit set");

   AST_OVERCURRENT_SET: assert property (
      quiet_s ##0 sync2_q[FLT_OVERCURRENT] |=> fault_q[FLT_OVERCURRENT])
      else $error("overcurrent flag not set");

   AST_INT_BRAKE_SET: assert property (
      quiet_s ##0 sync2_q[FLT_INT_BRAKE] |=> fault_q[FLT_INT_BRAKE])
      else $error("internal supply brake flag not set");

   AST_MAIN_BRAKE_SET: assert property (
      quiet_s ##0 sync2_q[FLT_MAIN_BRAKE] |=> fault_q[FLT_MAIN_BRAKE])
      else $error("main supply brake flag not set");

   AST_BRAKE_LOW_SET: assert property (
      quiet_s |=> (fault_q[10:8] & $past(sync2_q[10:8])) == $past(sync2_q[10:8]))
      else $error("brake low-side flag not set");

   AST_SWITCH_SET: assert property (
      quiet_s |=> (fault_q[5:0] & $past(sync2_q[5:0])) == $past(sync2_q[5:0]))
      else $error("switch overvoltage flag not set");

   AST_HOLD_UNTIL_READ: assert property (
      quiet_s ##0 fault_q[FLT_OVERCURRENT] && !rd_fault |=> fault_q[FLT_OVERCURRENT])
      else $error("flag dropped without a read");

   AST_SOFT_CLEARS_FAULTS: assert property (
      ce && soft_reset |=> fault_q == 16'h0000)
      else $error("soft reset left fault flags");

   AST_RESTART_KEEPS: assert property (
      restart_only_s |=> $stable(fault_q) && $stable(delay_q[0]) && $stable(delay_q[1]))
      else $error("restart changed latched state");

   AST_READ_THEN_CLEAR: assert property (
      fault_read_s |=> (fault_q == 16'h0000) && (hrdata[15:0] == $past(fault_q)))
      else $error("fault read did not return then clear");

   AST_PRESENT_RESETS: assert property (
      quiet_s ##0 rd_fault |=> fault_q == $past(fault_event))
      else $error("present fault not re-latched after read");

   AST_BRIDGE1_DELAY: assert property (
      quiet_s ##0 bridge1_meas_valid |=> (delay_q[0][13:8] == $past(bridge1_off_delay))
      && (delay_q[0][5:0] == $past(bridge1_on_delay)))
      else $error("bridge 1 delay not captured");

   AST_BRIDGE2_DELAY: assert property (
      quiet_s ##0 bridge2_meas_valid |=> (delay_q[1][13:8] == $past(bridge2_off_delay))
      && (delay_q[1][5:0] == $past(bridge2_on_delay)))
      else $error("bridge 2 delay not captured");

   AST_SOFT_CLEARS_DELAY: assert property (
      ce && soft_reset |=> (delay_q[0] == 16'h0000) && (delay_q[1] == 16'h0000))
      else $error("soft reset left delay values");

   AST_DELAY_READBACK: assert property (
      ce && addr_phase && !hwrite && (addr_idx == IDX_DELAY1) |=> hrdata == {16'h0000, $past(delay_q[0])})
      else $error("bridge 1 delay read mismatch");

endmodule

// file: ahb_host.sv
module ahb_host
   import bridge_status_pkg::*;
(
   // Clock and slave return
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // Master request
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0;
   end

   // One single word transfer; waits on hready in both phases
   task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rdata);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'h0};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rdata = hrdata;
   endtask
endmodule

// file: tb_top.sv
module tb_top
   import bridge_status_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] det;
   logic        v1, v2, soft_reset, restart, ce_in;
   logic [5:0]  off1, on1, off2, on2;
   int          fails, checked;
   int          pos[12] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 12, 13, 14};

   ahb_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
                  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   bridge_fault_delay_status_regs DUT (
      .hclk(hclk), .hresetn(hresetn), .ce(ce_in), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp),
      .high1_overvoltage(det[FLT_HIGH1]), .low1_overvoltage(det[FLT_LOW1]),
      .high2_overvoltage(det[FLT_HIGH2]), .low2_overvoltage(det[FLT_LOW2]),
      .high3_overvoltage(det[FLT_HIGH3]), .low3_overvoltage(det[FLT_LOW3]),
      .low1_brake_overvoltage(det[FLT_LOW1_BRK]), .low2_brake_overvoltage(det[FLT_LOW2_BRK]),
      .low3_brake_overvoltage(det[FLT_LOW3_BRK]), .main_supply_brake_flag(det[FLT_MAIN_BRAKE]),
      .internal_supply_brake_flag(det[FLT_INT_BRAKE]), .sense_overcurrent_flag(det[FLT_OVERCURRENT]),
      .bridge1_meas_valid(v1), .bridge1_off_delay(off1), .bridge1_on_delay(on1),
      .bridge2_meas_valid(v2), .bridge2_off_delay(off2), .bridge2_on_delay(on2),
      .soft_reset(soft_reset), .restart(restart), .irq(irq));

   initial
   begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      host.xfer(idx, 1'b0, 32'h0, rd);
      chk(exp, rd);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      host.xfer(idx, 1'b1, d, rd);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Detector high long enough to pass the synchronisers, then gone
   task automatic fault_pulse(input int i);
      @(posedge hclk);
      det[i] <= 1'b1;
      tick(3);
      det[i] <= 1'b0;
      tick(5);
   endtask

   // One-cycle pulse: 0 restart, 1 soft reset, otherwise bridge 1 valid
   task automatic pulse(input int sel);
      @(posedge hclk);
      case (sel)
         0:       restart <= 1'b1;
         1:       soft_reset <= 1'b1;
         default: v1 <= 1'b1;
      endcase
      @(posedge hclk);
      {restart, soft_reset, v1} <= 3'b000;
   endtask

   task automatic t_reset_values;
      rchk(IDX_FAULT, 32'h0);
      rchk(IDX_DELAY1, 32'h0);
      rchk(IDX_DELAY2, 32'h0);
      chk(32'h0, {31'h0, irq});
      chk(32'h0, {31'h0, hresp});
   endtask

   task automatic t_each_flag;
      foreach (pos[k])
      begin
         fault_pulse(pos[k]);
         rchk(IDX_FAULT, 32'h1 << pos[k]);
         rchk(IDX_FAULT, 32'h0);
      end
   endtask

   task automatic t_present_fault;
      @(posedge hclk);
      det[FLT_OVERCURRENT] <= 1'b1;
      tick(5);
      wr(IDX_FAULT, 32'hFFFF);
      rchk(IDX_FAULT, 32'h4000);
      rchk(IDX_FAULT, 32'h4000);
      det[FLT_OVERCURRENT] <= 1'b0;
      tick(5);
      rchk(IDX_FAULT, 32'h4000);
      rchk(IDX_FAULT, 32'h0);
   endtask

   task automatic t_delays;
      @(posedge hclk);
      {v1, off1, on1, v2, off2, on2} <= {1'b1, 6'h3F, 6'h2A, 1'b1, 6'h15, 6'h3F};
      @(posedge hclk);
      {v1, off1, on1, v2, off2, on2} <= {1'b0, 6'h01, 6'h02, 1'b0, 6'h03, 6'h04};
      rchk(IDX_DELAY1, 32'h3F2A);
      rchk(IDX_DELAY2, 32'h153F);
      wr(IDX_DELAY1, 32'hFFFF);
      rchk(IDX_DELAY1, 32'h3F2A);
      rchk(8'h70, 32'h0);
   endtask

   task automatic t_reset_classes;
      fault_pulse(FLT_LOW3);
      pulse(0);
      rchk(IDX_FAULT, 32'h0020);
      rchk(IDX_DELAY1, 32'h3F2A);
      rchk(IDX_DELAY2, 32'h153F);
      fault_pulse(FLT_HIGH1);
      pulse(1);
      rchk(IDX_FAULT, 32'h0);
      rchk(IDX_DELAY1, 32'h0);
      rchk(IDX_DELAY2, 32'h0);
   endtask

   // Clock enable low must freeze the delay capture
   task automatic t_freeze;
      @(posedge hclk);
      ce_in <= 1'b0;
      {v1, off1, on1} <= {1'b1, 6'h11, 6'h22};
      @(posedge hclk);
      v1 <= 1'b0;
      @(posedge hclk);
      ce_in <= 1'b1;
      rchk(IDX_DELAY1, 32'h0);
      chk(32'h0, {31'h0, hresp});
   endtask

   task automatic t_interrupt;
      wr(IDX_IRQ_MASK, 32'h1);
      wr(IDX_IRQ_STATUS, 32'h3);
      tick(2);
      chk(32'h0, {31'h0, irq});
      fault_pulse(FLT_HIGH2);
      chk(32'h1, {31'h0, irq});
      rchk(IDX_IRQ_STATUS, 32'h1);
      wr(IDX_IRQ_MASK, 32'h0);
      tick(2);
      chk(32'h0, {31'h0, irq});
      wr(IDX_IRQ_MASK, 32'h1);
      tick(2);
      chk(32'h1, {31'h0, irq});
      rchk(IDX_FAULT, 32'h0004);
      wr(IDX_IRQ_STATUS, 32'h1);
      tick(2);
      chk(32'h0, {31'h0, irq});
      pulse(2);
      tick(2);
      rchk(IDX_IRQ_STATUS, 32'h2);
      chk(32'h0, {31'h0, irq});
   endtask

   task automatic conclude;
      if (fails == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      #2000000;
      fails++;
      conclude();
   end

   initial
   begin
      fails = 0;
      checked = 0;
      hresetn = 1'b0;
      det = 16'h0;
      {v1, off1, on1, v2, off2, on2, soft_reset, restart} = '0;
      ce_in = 1'b1;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset_values();
      t_each_flag();
      t_present_fault();
      t_delays();
      t_reset_classes();
      t_freeze();
      t_interrupt();
      conclude();
   end
endmodule
